// *** rtl/nesl_logger.sv ***
// Bridge error signature logger top: encodes and captures one error per event.
// Assumes events arrive as one-cycle pulses in the clk domain; reads are registered
// selects of captured registers. Only the bank address register is addressed.
//
// Functional notes
// - Each error type maps to a thresholding group
// - Protocol errors count to link group only
// - Action class D for every type
// - Five-bit extended code logged per type
// - Abort target class reports attached link kind
// - Status flags per type as tabulated
// - DRAM ECC flags follow multi-symbol indication
// - L3 flags follow multi-bit and single-bit
// - Abort and GART corrupt flag equals core source
// - Link retries from either end logged, not uncorrected
// - L3 entries hold way and subcache number
// - Core index valid only when non-zero
// - Address bits 47:1 location, rest zero
// - Address undefined at cold reset, master gated
// - Protocol address with reason in bits 5:1
// - Watchdog format chosen by address valid
// - Other address-valid errors store physical address
// - Link protocol reason codes as listed
// - L3 protocol reason codes as listed
// - Invalid command code by retry mode; the logic passes 01010b through in either mode
// - Control deassert logged only without retry mode
// - Data-phase violations use their own codes
`timescale 1ns/1ns
module nesl_logger
  import nesl_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Error event
  input  wire logic            err_valid,
  input  wire nesl_event_type  err_event,
  input  wire logic            bank_enable,
  input  wire logic            retry_mode,
  input  wire logic            ctl_deassert_idle,
  input  wire logic            watchdog_address_log_mode,
  input  wire logic            report_to_master_core_enable,
  // Register access
  input  wire logic            reg_rd,
  input  wire logic            reg_wr,
  input  wire logic [11:0]     reg_addr,
  input  wire logic [63:0]     reg_wdata,
  input  wire logic            req_master_core,
  output nesl_status_type      status_out,
  output logic [63:0]          reg_rdata,
  output logic                 reg_denied,
  output logic                 retry_start,
  output logic                 threshold_link_inc,
  output logic                 threshold_dram_inc,
  output logic                 threshold_l3_inc,
  output logic                 error_action
);

  // ==========================================================================
  // Protocol reason resolution
  // A control deassert with retry mode on is not a protocol error; it starts a retry.
  wire ctl_retry     = ctl_deassert_idle && retry_mode;
  wire ctl_log       = ctl_deassert_idle && !retry_mode;
  wire is_prot       = err_valid && (err_event.err_type == NESL_EXT_PROTOCOL);
  wire rsvd_reason   = err_event.reason[4:2] == NESL_PR_RSVD_HI;
  // Reasons pass straight through: link codes, data-phase codes, invalid command
  // code 01010b (caller reports it under either retry condition) and L3 codes.
  wire prot_drop     = is_prot && (rsvd_reason ||
                       (err_event.reason == NESL_PR_CTL_DEASSRT && retry_mode));
  wire ev_ok         = err_valid && !prot_drop && err_event.err_type != NESL_EXT_RESERVED;
  // A coincident accepted error keeps its own log; the deassert is never merged into it
  wire ctl_only      = ctl_log && !ev_ok;
  wire [4:0] reason_w = ctl_only ? NESL_PR_CTL_DEASSRT : err_event.reason;
  wire take_event    = ev_ok || ctl_log;

  nesl_event_type ev_w;
  always_comb begin
    ev_w = err_event;
    // Watchdog address counts as valid only in the physical-address log mode
    if (err_event.err_type == NESL_EXT_WDT) begin
      ev_w.addr_known = err_event.addr_known && watchdog_address_log_mode;
    end
    if (ctl_only) begin
      ev_w          = '0;
      ev_w.err_type = NESL_EXT_PROTOCOL;
      ev_w.from_link = 1'b1;
      ev_w.link     = err_event.link;
    end
    ev_w.reason = reason_w;
  end

  // ==========================================================================
  // Encoders
  nesl_status_type st_w;
  logic [63:0]     addr_w;

  nesl_flag_encode u_flags (
    .ev (ev_w),
    .st (st_w)
  );

  nesl_addr_format u_addr (
    .err_type     (ev_w.err_type),
    .addr_valid   (st_w.address_valid),
    .wdt_log_mode (watchdog_address_log_mode),
    .reason       (ev_w.reason),
    .phys_addr    (ev_w.phys_addr),
    .wdt_diag     (ev_w.wdt_diag),
    .addr         (addr_w)
  );

  // ==========================================================================
  // Log registers
  // The address register has no defined cold value; only status is reset.
  nesl_status_type status_reg;
  logic [63:0]     addr_reg;
  logic            hw_write;

  wire sel_addr  = reg_addr == NESL_BANK_ADDR_OFS;
  wire allowed   = req_master_core || !report_to_master_core_enable;
  wire sw_write  = reg_wr && sel_addr && allowed;
  wire act_w     = (st_w.action == NESL_AC_DETECT) || bank_enable;

  assign hw_write = take_event;

  // Hardware capture wins over a simultaneous software write
  always_ff @(posedge clk) begin
    if (hw_write) begin
      addr_reg <= addr_w;
    end else if (sw_write) begin
      addr_reg <= {16'h0000, reg_wdata[NESL_LOC_MSB:NESL_LOC_LSB], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
    end else if (hw_write) begin
      status_reg <= st_w;
    end
  end

  // ==========================================================================
  // Event side outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_start        <= 1'b0;
      threshold_link_inc <= 1'b0;
      threshold_dram_inc <= 1'b0;
      threshold_l3_inc   <= 1'b0;
      error_action       <= 1'b0;
    end else begin
      retry_start        <= ctl_retry;
      threshold_link_inc <= hw_write && st_w.group == NESL_TG_LINK;
      threshold_dram_inc <= hw_write && st_w.group == NESL_TG_DRAM;
      threshold_l3_inc   <= hw_write && st_w.group == NESL_TG_L3;
      error_action       <= hw_write && act_w;
    end
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= '0;
      reg_denied <= 1'b0;
    end else begin
      reg_rdata  <= (reg_rd && sel_addr && allowed) ? addr_reg : '0;
      reg_denied <= (reg_rd || reg_wr) && sel_addr && !allowed;
    end
  end

  assign status_out = status_reg;

  // ==========================================================================
  // Checks
  property p_group_dram;
    @(posedge clk) disable iff (!rst_n)
      (take_event && ev_w.err_type == NESL_EXT_DRAM_ECC) |=> threshold_dram_inc;
  endproperty
  a_group_dram: assert property (p_group_dram) else $error("dram group miss");

  property p_prot_nolink;
    @(posedge clk) disable iff (!rst_n)
      (take_event && ev_w.err_type == NESL_EXT_PROTOCOL && !ev_w.from_link)
        |=> !threshold_link_inc;
  endproperty
  a_prot_nolink: assert property (p_prot_nolink) else $error("protocol counted");

  property p_code;
    @(posedge clk) disable iff (!rst_n)
      take_event |=> status_reg.ext_code == $past(ev_w.err_type);
  endproperty
  a_code: assert property (p_code) else $error("ext code wrong");

  property p_dram_flags;
    @(posedge clk) disable iff (!rst_n)
      (take_event && ev_w.err_type == NESL_EXT_DRAM_ECC)
        |=> status_reg.correctable == !status_reg.uncorrectable &&
            status_reg.uncorrected == status_reg.uncorrectable;
  endproperty
  a_dram_flags: assert property (p_dram_flags) else $error("dram flags");

  property p_retry_uc;
    @(posedge clk) disable iff (!rst_n)
      (take_event && ev_w.err_type == NESL_EXT_RETRY)
        |=> !status_reg.uncorrected && !status_reg.address_valid;
  endproperty
  a_retry_uc: assert property (p_retry_uc) else $error("retry marked uc");

  property p_addr_zero;
    @(posedge clk) disable iff (!rst_n)
      take_event |=> addr_reg[63:48] == 16'h0000 && !addr_reg[0];
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("reserved addr bits");

  property p_prot_reason;
    @(posedge clk) disable iff (!rst_n)
      (take_event && ev_w.err_type == NESL_EXT_PROTOCOL)
        |=> addr_reg[5:1] == $past(ev_w.reason);
  endproperty
  a_prot_reason: assert property (p_prot_reason) else $error("reason lost");

  property p_ctl_retry;
    @(posedge clk) disable iff (!rst_n)
      (ctl_deassert_idle && retry_mode && !err_valid) |=> retry_start && !threshold_link_inc;
  endproperty
  a_ctl_retry: assert property (p_ctl_retry) else $error("retry not started");

  property p_abort_pcc;
    @(posedge clk) disable iff (!rst_n)
      (take_event && ev_w.err_type == NESL_EXT_MST_ABORT)
        |=> status_reg.context_corrupt == $past(ev_w.from_core);
  endproperty
  a_abort_pcc: assert property (p_abort_pcc) else $error("abort pcc");

endmodule

// *** inc/nesl_pkg.sv ***
// Package for the bridge error signature logger: error types, codes, flags, layouts.
// Assumes a single clock domain and an error event presented as one-cycle pulse.
package nesl_pkg;

  // ==========================================================================
  // Error type selectors (extended error code values)
  localparam logic [4:0] NESL_EXT_RESERVED  = 5'h00;
  localparam logic [4:0] NESL_EXT_CRC       = 5'h01;
  localparam logic [4:0] NESL_EXT_SYNC      = 5'h02;
  localparam logic [4:0] NESL_EXT_MST_ABORT = 5'h03;
  localparam logic [4:0] NESL_EXT_TGT_ABORT = 5'h04;
  localparam logic [4:0] NESL_EXT_GART      = 5'h05;
  localparam logic [4:0] NESL_EXT_RMW       = 5'h06;
  localparam logic [4:0] NESL_EXT_WDT       = 5'h07;
  localparam logic [4:0] NESL_EXT_DRAM_ECC  = 5'h08;
  localparam logic [4:0] NESL_EXT_LINK_DATA = 5'h0a;
  localparam logic [4:0] NESL_EXT_PROTOCOL  = 5'h0b;
  localparam logic [4:0] NESL_EXT_ARRAY     = 5'h0c;
  localparam logic [4:0] NESL_EXT_DRAM_PAR  = 5'h0d;
  localparam logic [4:0] NESL_EXT_RETRY     = 5'h0e;
  localparam logic [4:0] NESL_EXT_GART_TWD  = 5'h0f;
  localparam logic [4:0] NESL_EXT_CU_DATA   = 5'h19;
  localparam logic [4:0] NESL_EXT_L3_DATA   = 5'h1c;
  localparam logic [4:0] NESL_EXT_L3_TAG    = 5'h1d;
  localparam logic [4:0] NESL_EXT_L3_LRU    = 5'h1e;
  localparam logic [4:0] NESL_EXT_PF        = 5'h1f;

  // ==========================================================================
  // Protocol fault reasons
  localparam logic [4:0] NESL_PR_PROBE_RSP   = 5'h01;
  localparam logic [4:0] NESL_PR_TGT_DONE    = 5'h02;
  localparam logic [4:0] NESL_PR_TGT_START   = 5'h03;
  localparam logic [4:0] NESL_PR_CMD_OVF     = 5'h04;
  localparam logic [4:0] NESL_PR_DATA_OVF    = 5'h05;
  localparam logic [4:0] NESL_PR_RETRY_OVF   = 5'h06;
  localparam logic [4:0] NESL_PR_DATA_MID    = 5'h07;
  localparam logic [4:0] NESL_PR_ADDR_EXT    = 5'h08;
  localparam logic [4:0] NESL_PR_BAD_CMD     = 5'h0a;
  localparam logic [4:0] NESL_PR_CTL_DEASSRT = 5'h0b;
  localparam logic [2:0] NESL_PR_RSVD_HI     = 3'h3;   // 011xx reserved
  localparam logic [4:0] NESL_PR_L3_REQ_MULT = 5'h10;
  localparam logic [4:0] NESL_PR_L3_PRB_MULT = 5'h11;
  localparam logic [4:0] NESL_PR_L3_RQ_OVF   = 5'h12;
  localparam logic [4:0] NESL_PR_L3_WRVIC    = 5'h13;
  localparam logic [4:0] NESL_PR_L3_BASE     = 5'h10;

  // ==========================================================================
  // Register map and address layout
  localparam logic [11:0] NESL_BANK_ADDR_OFS = 12'h412;
  localparam int          NESL_LOC_LSB       = 1;
  localparam int          NESL_LOC_MSB       = 47;
  localparam int          NESL_PADDR_LSB     = 6;
  localparam int          NESL_REASON_MSB    = 5;

  // ==========================================================================
  typedef enum logic [1:0] {
    NESL_TG_NONE = 2'b00,
    NESL_TG_LINK = 2'b01,
    NESL_TG_DRAM = 2'b10,
    NESL_TG_L3   = 2'b11
  } nesl_group_type;

  typedef enum logic {
    NESL_AC_DETECT  = 1'b0,   // Class D
    NESL_AC_ENABLED = 1'b1    // Class E
  } nesl_action_type;

  typedef enum logic [1:0] {
    NESL_TC_GEN = 2'b00,
    NESL_TC_MEM = 2'b01,
    NESL_TC_IO  = 2'b10
  } nesl_tclass_type;

  // Event from the detecting units
  typedef struct packed {
    logic [4:0]  err_type;
    logic        from_link;        // Protocol error raised by a link
    logic        from_core;        // Request sourced from a core
    logic        coherent_link;    // Reporting unit faces a coherent link
    logic        multi_symbol;
    logic        multi_bit;
    logic        single_bit;
    logic        scrub;
    logic        addr_known;       // Protocol / watchdog address available
    logic [4:0]  reason;
    logic [3:0]  link;             // Link number or L3 way
    logic [1:0]  subcache;
    logic [3:0]  core_index;
    logic [15:0] syndrome;
    logic [47:1] phys_addr;
    logic [47:1] wdt_diag;
  } nesl_event_type;

  // Status image
  typedef struct packed {
    logic            uncorrected;
    logic            address_valid;
    logic            context_corrupt;
    logic            correctable;
    logic            uncorrectable;
    logic            scrub;
    logic            syndrome_valid;
    logic [15:0]     syndrome;
    logic [3:0]      link;
    logic [1:0]      subcache;
    logic [3:0]      core_index;
    logic [4:0]      ext_code;
    nesl_group_type  group;
    nesl_action_type action;
    nesl_tclass_type tclass;
  } nesl_status_type;

endpackage

// *** rtl/nesl_flag_encode.sv ***
// Combinational status flag encoder for one error event.
// Assumes the event fields are stable in the cycle they are presented.
`timescale 1ns/1ns
module nesl_flag_encode
  import nesl_pkg::*;
(
  input  wire nesl_event_type  ev,
  output nesl_status_type      st
);

  // ==========================================================================
  // Classification
  wire is_l3      = (ev.err_type == NESL_EXT_L3_DATA) || (ev.err_type == NESL_EXT_L3_TAG) ||
                    (ev.err_type == NESL_EXT_L3_LRU);
  wire is_pf      = (ev.err_type == NESL_EXT_PF);
  wire is_l3_ecc  = (ev.err_type == NESL_EXT_L3_DATA) || (ev.err_type == NESL_EXT_L3_TAG);
  wire is_dram    = (ev.err_type == NESL_EXT_DRAM_ECC);
  wire is_abort   = (ev.err_type == NESL_EXT_MST_ABORT) || (ev.err_type == NESL_EXT_TGT_ABORT);
  wire core_pcc   = is_abort || (ev.err_type == NESL_EXT_GART);
  wire no_addr    = (ev.err_type == NESL_EXT_CRC) || (ev.err_type == NESL_EXT_SYNC) ||
                    (ev.err_type == NESL_EXT_DRAM_PAR) || (ev.err_type == NESL_EXT_RETRY) ||
                    (ev.err_type == NESL_EXT_CU_DATA);
  wire addr_opt   = (ev.err_type == NESL_EXT_PROTOCOL) || (ev.err_type == NESL_EXT_WDT);
  wire no_uc      = (ev.err_type == NESL_EXT_RETRY) || (ev.err_type == NESL_EXT_L3_LRU) || is_pf;
  wire pcc_zero   = (ev.err_type == NESL_EXT_RMW) || (ev.err_type == NESL_EXT_LINK_DATA) ||
                    (ev.err_type == NESL_EXT_RETRY) || (ev.err_type == NESL_EXT_GART_TWD) ||
                    (ev.err_type == NESL_EXT_L3_LRU) || is_pf;
  wire uc_l3      = ev.multi_bit;

  wire uc_w   = is_dram ? ev.multi_symbol : (is_l3_ecc ? uc_l3 : !no_uc);
  wire pcc_w  = is_dram   ? (ev.multi_symbol && ev.from_core) :
                core_pcc  ? ev.from_core :
                is_l3_ecc ? uc_l3 :
                !pcc_zero;
  wire grp_l  = !(is_l3 || is_pf || is_dram || (ev.err_type == NESL_EXT_DRAM_PAR) ||
                  (ev.err_type == NESL_EXT_ARRAY) || (ev.err_type == NESL_EXT_CU_DATA) ||
                  (ev.err_type == NESL_EXT_PROTOCOL));
  wire syn_ok = is_dram || is_l3_ecc || is_pf;

  always_comb begin
    st                 = '0;
    st.ext_code        = ev.err_type;
    st.uncorrected     = uc_w;
    st.address_valid   = no_addr ? 1'b0 : (addr_opt ? ev.addr_known : 1'b1);
    st.context_corrupt = pcc_w;
    st.correctable     = is_dram ? !ev.multi_symbol :
                         (is_l3_ecc || is_pf) ? ev.single_bit : 1'b0;
    st.uncorrectable   = is_dram ? ev.multi_symbol :
                         (is_l3_ecc || is_pf) ? ev.multi_bit : 1'b0;
    st.scrub           = (is_dram || is_l3_ecc || is_pf) ? ev.scrub : 1'b0;
    st.syndrome_valid  = syn_ok;
    st.syndrome        = syn_ok ? ev.syndrome : '0;
    st.link            = ev.link;
    st.subcache        = (is_l3 || is_pf) ? ev.subcache : '0;
    st.core_index      = ev.core_index;
    // Thresholding group
    if (is_dram || ev.err_type == NESL_EXT_DRAM_PAR) begin
      st.group = NESL_TG_DRAM;
    end else if (is_l3 || is_pf) begin
      st.group = NESL_TG_L3;
    end else if (ev.err_type == NESL_EXT_PROTOCOL) begin
      st.group = ev.from_link ? NESL_TG_LINK : NESL_TG_NONE;
    end else if (grp_l) begin
      st.group = NESL_TG_LINK;
    end else begin
      st.group = NESL_TG_NONE;
    end
    st.action = NESL_AC_DETECT;
    if (is_abort) begin
      st.tclass = ev.coherent_link ? NESL_TC_MEM : NESL_TC_IO;
    end else if (is_dram) begin
      st.tclass = NESL_TC_MEM;
    end else if (ev.err_type == NESL_EXT_RMW) begin
      st.tclass = NESL_TC_IO;
    end else begin
      st.tclass = NESL_TC_GEN;
    end
  end

endmodule

// *** rtl/nesl_addr_format.sv ***
// Combinational composer for the 64-bit bank error address.
// Assumes reason codes already resolved by the caller.
`timescale 1ns/1ns
module nesl_addr_format
  import nesl_pkg::*;
(
  input  wire logic [4:0]  err_type,
  input  wire logic        addr_valid,
  input  wire logic        wdt_log_mode,
  input  wire logic [4:0]  reason,
  input  wire logic [47:1] phys_addr,
  input  wire logic [47:1] wdt_diag,
  output logic      [63:0] addr
);

  logic [47:1] loc;

  always_comb begin
    loc = '0;
    if (err_type == NESL_EXT_PROTOCOL) begin
      if (addr_valid) begin
        loc[NESL_LOC_MSB:NESL_PADDR_LSB] = phys_addr[NESL_LOC_MSB:NESL_PADDR_LSB];
      end
      loc[NESL_REASON_MSB:NESL_LOC_LSB] = reason;
    end else if (err_type == NESL_EXT_WDT) begin
      // Mode bit and address valid together pick physical address over diagnostic
      loc = (addr_valid && wdt_log_mode) ? phys_addr : wdt_diag;
    end else if (addr_valid) begin
      loc = phys_addr;
    end
    addr = {16'h0000, loc, 1'b0};
  end

endmodule

// *** verification/nesl_logger_tb.sv ***
// Self-checking bench for the bridge error signature logger.
// Assumes nesl_pkg is compiled first; bench drives all ports of nesl_logger.
`timescale 1ns/1ns
module testbench;
  import nesl_pkg::*;
  logic            clk, rst_n, err_valid, bank_enable, retry_mode, ctl_idle;
  logic            wmode, rmce, reg_rd, reg_wr, req_master_core;
  logic [11:0]     reg_addr;
  logic [63:0]     reg_wdata, reg_rdata, ad;
  nesl_event_type  ev;
  nesl_status_type so;
  logic            den, retry_start, tl, td, t3, act;
  int              fail_count, cmp_count;

  nesl_logger u_dut (.clk(clk), .rst_n(rst_n), .err_valid(err_valid), .err_event(ev),
    .bank_enable(bank_enable), .retry_mode(retry_mode), .ctl_deassert_idle(ctl_idle),
    .watchdog_address_log_mode(wmode), .report_to_master_core_enable(rmce),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .req_master_core(req_master_core), .status_out(so), .reg_rdata(reg_rdata),
    .reg_denied(den), .retry_start(retry_start), .threshold_link_inc(tl),
    .threshold_dram_inc(td), .threshold_l3_inc(t3), .error_action(act));

  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic nesl_event_type mk(input logic [4:0] t);
    mk = '0;
    mk.err_type = t;
    mk.phys_addr = 47'h2a5b_3c4d_5e6f;
    mk.wdt_diag = 47'h1357_9bdf_0246;
  endfunction
  // Outputs are sampled just after the taking edge, where the pulses stand
  task automatic send(input nesl_event_type e);
    @(posedge clk);
    err_valid <= 1'b1;
    ev <= e;
    @(posedge clk);
    err_valid <= 1'b0;
    #1;
  endtask
  // Flags: uc, av, pcc, correctable_flag, uncorrectable_flag; groups: link, dram, l3, action
  task automatic fl(input logic [4:0] f, input logic [3:0] g);
    chk({so.uncorrected, so.address_valid, so.context_corrupt, so.correctable,
         so.uncorrectable}, f);
    chk({tl, td, t3, act}, g);
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_rd <= !w;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    ad = reg_rdata;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_dram();
    nesl_event_type e;
    e = mk(NESL_EXT_DRAM_ECC);
    e.multi_symbol = 1'b1;
    e.from_core = 1'b1;
    e.syndrome = 16'hbeef;
    send(e);
    fl(5'b11101, 4'b0101);
    chk(so.ext_code, 5'h08);
    chk(so.syndrome, 16'hbeef);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk(ad, {16'h0, e.phys_addr, 1'b0});
    e.multi_symbol = 1'b0;
    send(e);
    fl(5'b01010, 4'b0101);
  endtask
  task automatic t_abort();
    nesl_event_type e;
    e = mk(NESL_EXT_MST_ABORT);
    e.coherent_link = 1'b1;
    e.from_core = 1'b1;
    send(e);
    fl(5'b11100, 4'b1001);
    chk(so.tclass, NESL_TC_MEM);
    e.err_type = NESL_EXT_TGT_ABORT;
    e.coherent_link = 1'b0;
    e.from_core = 1'b0;
    send(e);
    fl(5'b11000, 4'b1001);
    chk(so.tclass, NESL_TC_IO);
    e = mk(NESL_EXT_RETRY);
    send(e);
    fl(5'b00000, 4'b1001);
    e = mk(NESL_EXT_CRC);
    bank_enable <= 1'b0;
    send(e);
    fl(5'b10100, 4'b1001);
    bank_enable <= 1'b1;
  endtask
  task automatic t_l3();
    nesl_event_type e;
    e = mk(NESL_EXT_L3_DATA);
    e.multi_bit = 1'b1;
    e.link = 4'h5;
    e.subcache = 2'h2;
    e.core_index = 4'h3;
    send(e);
    fl(5'b11101, 4'b0011);
    chk({so.link, so.subcache}, 6'h16);
    chk({so.core_index, so.syndrome_valid}, 5'h07);
    e.err_type = NESL_EXT_PF;
    e.multi_bit = 1'b0;
    e.single_bit = 1'b1;
    send(e);
    fl(5'b01010, 4'b0011);
  endtask
  task automatic t_proto();
    nesl_event_type e;
    e = mk(NESL_EXT_PROTOCOL);
    e.from_link = 1'b1;
    e.addr_known = 1'b1;
    e.reason = NESL_PR_CMD_OVF;
    send(e);
    fl(5'b11100, 4'b1001);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk(ad, {16'h0, e.phys_addr[47:6], 5'h04, 1'b0});
    e.from_link = 1'b0;
    e.addr_known = 1'b0;
    e.reason = NESL_PR_L3_WRVIC;
    send(e);
    fl(5'b10100, 4'b0001);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk({ad[63:48], ad[5:0]}, {16'h0, 5'h13, 1'b0});
    e.reason = 5'h0d;
    send(e);
    chk({tl, td, t3, act}, 4'h0);
    send(mk(NESL_EXT_RESERVED));
    chk({tl, td, t3, act}, 4'h0);
  endtask
  task automatic t_wdt();
    nesl_event_type e;
    e = mk(NESL_EXT_WDT);
    wmode <= 1'b1;
    send(e);
    fl(5'b10100, 4'b1001);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk(ad, {16'h0, e.wdt_diag, 1'b0});
    e.addr_known = 1'b1;
    send(e);
    fl(5'b11100, 4'b1001);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk(ad, {16'h0, e.phys_addr, 1'b0});
    wmode <= 1'b0;
    send(e);
    fl(5'b10100, 4'b1001);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk(ad, {16'h0, e.wdt_diag, 1'b0});
  endtask
  task automatic t_ctl();
    retry_mode <= 1'b1;
    @(posedge clk);
    ctl_idle <= 1'b1;
    @(posedge clk);
    ctl_idle <= 1'b0;
    #1;
    chk({retry_start, tl}, 2'b10);
    retry_mode <= 1'b0;
    @(posedge clk);
    ctl_idle <= 1'b1;
    @(posedge clk);
    ctl_idle <= 1'b0;
    #1;
    chk({retry_start, tl, so.ext_code}, {2'b01, 5'h0b});
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk(ad[5:0], {NESL_PR_CTL_DEASSRT, 1'b0});
  endtask
  task automatic t_reg();
    acc(1'b1, NESL_BANK_ADDR_OFS, 64'hffff_ffff_ffff_ffff);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk(ad, 64'h0000_ffff_ffff_fffe);
    acc(1'b0, 12'h413, '0);
    chk(ad, 64'h0);
    rmce <= 1'b1;
    acc(1'b1, NESL_BANK_ADDR_OFS, 64'h0);
    chk(den, 1'b1);
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk({den, ad}, {1'b1, 64'h0});
    req_master_core <= 1'b1;
    acc(1'b0, NESL_BANK_ADDR_OFS, '0);
    chk({den, ad}, {1'b0, 64'h0000_ffff_ffff_fffe});
  endtask

  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    {rst_n, err_valid, bank_enable, retry_mode, ctl_idle, wmode, rmce} = '0;
    {reg_rd, reg_wr, req_master_core, reg_addr, reg_wdata} = '0;
    ev = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bank_enable <= 1'b1;
    t_dram();
    t_abort();
    t_l3();
    t_proto();
    t_wdt();
    t_ctl();
    t_reg();
    end_of_test();
  end
endmodule
